// >>> rtl/mic_bitstream_controller.sv
// Result storage, flags, DMA trigger, interrupt mask and APB registers
`timescale 1ns/1ps
module mic_bitstream_controller #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Filtered samples
  input wire logic sample_valid_i,
  input wire logic [31:0] sample_data_i,
  input wire logic [mic_regs_pkg::QUEUED_W-1:0] queued_sample_count_i,
  // DMA channel
  input wire logic dma_rx_counter_zero_i,
  input wire logic dma_rx_next_counter_zero_i,
  input wire logic dma_counter_write_i,
  output logic dma_req_o,
  output logic [mic_regs_pkg::SAMPLE_W-1:0] dma_data_o,
  // Filter and microphone controls
  output logic conversion_run_o,
  output logic soft_reset_o,
  output logic mic_sample_clock_o,
  output logic [31:0] filter_config_a_o,
  output logic [31:0] filter_config_b_o,
  // Interrupt
  output logic irq_o
);

  typedef struct packed {
    logic run;
    logic [31:0] mode;
    logic [31:0] sample;
    logic ready;
    logic overrun;
    logic [3:0] mask;
    logic [31:0] filt_a;
    logic [31:0] filt_b;
    logic wp_on;
    logic wp_flag;
    logic [mic_regs_pkg::WP_SRC_W-1:0] wp_src;
    logic [31:0] rdata;
    logic rd_fresh;
    logic dma_req;
    logic soft_reset_bit;
    logic irq;
  } ctrl_state_t;

  localparam ctrl_state_t RESET_STATE = '{
    run: 1'b0,
    mode: mic_regs_pkg::RST_MODE,
    sample: 32'h00000000,
    ready: 1'b0,
    overrun: 1'b0,
    mask: 4'h0,
    filt_a: mic_regs_pkg::RST_FILTER_A,
    filt_b: mic_regs_pkg::RST_FILTER_B,
    wp_on: 1'b0,
    wp_flag: 1'b0,
    wp_src: 16'h0000,
    rdata: 32'h00000000,
    rd_fresh: 1'b0,
    dma_req: 1'b0,
    soft_reset_bit: 1'b0,
    irq: 1'b0
  };

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  logic rx_done;
  logic rx_full;
  logic [11:0] ofs;

  // Word-aligned byte offset
  assign ofs = 12'({paddr_i[ADDR_W-1:2], 2'b00});

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // Maps the four interrupt sources onto their status and mask bit positions
  function automatic logic [31:0] place_sources(input logic [3:0] s);
    logic [31:0] v;
    v = 32'h00000000;
    v[mic_regs_pkg::IRQ_READY_BIT] = s[0];
    v[mic_regs_pkg::IRQ_OVERRUN_BIT] = s[1];
    v[mic_regs_pkg::IRQ_RX_DONE_BIT] = s[2];
    v[mic_regs_pkg::IRQ_RX_FULL_BIT] = s[3];
    place_sources = v;
  endfunction

  function automatic logic [3:0] pick_sources(input logic [31:0] v);
    pick_sources = {v[mic_regs_pkg::IRQ_RX_FULL_BIT], v[mic_regs_pkg::IRQ_RX_DONE_BIT],
                    v[mic_regs_pkg::IRQ_OVERRUN_BIT], v[mic_regs_pkg::IRQ_READY_BIT]};
  endfunction

  logic setup;
  logic wr;
  logic rd;
  logic sample_taken;
  logic store;
  logic overrun_evt;
  logic protected_hit;
  logic [31:0] read_mux;
  logic [3:0] status_nxt;

  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;

  // Read data, captured in the setup phase
  always_comb begin
    read_mux = 32'h00000000;
    if (hit(ofs, mic_regs_pkg::OFS_CONTROL)) begin
      read_mux[mic_regs_pkg::CTRL_RUN_BIT] = st_r.run;
    end else if (hit(ofs, mic_regs_pkg::OFS_MODE)) begin
      read_mux = st_r.mode;
    end else if (hit(ofs, mic_regs_pkg::OFS_SAMPLE)) begin
      read_mux = st_r.sample;
    end else if (hit(ofs, mic_regs_pkg::OFS_IRQ_MASK)) begin
      read_mux = place_sources(st_r.mask);
    end else if (hit(ofs, mic_regs_pkg::OFS_IRQ_STATUS)) begin
      read_mux = place_sources({rx_full, rx_done, st_r.overrun, st_r.ready});
      read_mux[mic_regs_pkg::QUEUED_LSB +: mic_regs_pkg::QUEUED_W] = queued_sample_count_i;
    end else if (hit(ofs, mic_regs_pkg::OFS_FILTER_A)) begin
      read_mux = st_r.filt_a;
    end else if (hit(ofs, mic_regs_pkg::OFS_FILTER_B)) begin
      read_mux = st_r.filt_b;
    end else if (hit(ofs, mic_regs_pkg::OFS_WP_MODE)) begin
      read_mux[mic_regs_pkg::WP_ON_BIT] = st_r.wp_on;
    end else if (hit(ofs, mic_regs_pkg::OFS_WP_STATUS)) begin
      read_mux[mic_regs_pkg::WP_FLAG_BIT] = st_r.wp_flag;
      read_mux[mic_regs_pkg::WP_SRC_LSB +: mic_regs_pkg::WP_SRC_W] = st_r.wp_src;
    end
  end

  // a read clears ready unless a new result landed after capture
  assign sample_taken = rd && hit(ofs, mic_regs_pkg::OFS_SAMPLE) && !st_r.rd_fresh;
  // store only while running and nothing unread, or the unread result is taken this cycle
  assign store = sample_valid_i && st_r.run && (!st_r.ready || sample_taken);
  // new result while ready is still set
  assign overrun_evt = sample_valid_i && st_r.run && st_r.ready && !sample_taken;
  assign protected_hit = hit(ofs, mic_regs_pkg::OFS_MODE) ||
                         hit(ofs, mic_regs_pkg::OFS_FILTER_A) ||
                         hit(ofs, mic_regs_pkg::OFS_FILTER_B);

  always_comb begin
    st_nxt = st_r;
    st_nxt.dma_req = 1'b0;
    st_nxt.soft_reset_bit = 1'b0;
    if (setup) begin
      st_nxt.rdata = read_mux;
      st_nxt.rd_fresh = 1'b0;
    end
    if (store && (setup || st_r.rd_fresh)) begin
      st_nxt.rd_fresh = 1'b1;
    end
    if (sample_taken) begin
      st_nxt.ready = 1'b0;
    end
    // clear on status read, only what was reported
    if (rd && hit(ofs, mic_regs_pkg::OFS_IRQ_STATUS) &&
        st_r.rdata[mic_regs_pkg::IRQ_OVERRUN_BIT]) begin
      st_nxt.overrun = 1'b0;
    end
    if (rd && hit(ofs, mic_regs_pkg::OFS_WP_STATUS) &&
        st_r.rdata[mic_regs_pkg::WP_FLAG_BIT]) begin
      st_nxt.wp_flag = 1'b0;
    end
    if (wr) begin
      if (hit(ofs, mic_regs_pkg::OFS_CONTROL)) begin
        // run bit starts and stops conversions
        st_nxt.run = pwdata_i[mic_regs_pkg::CTRL_RUN_BIT];
        st_nxt.soft_reset_bit = pwdata_i[mic_regs_pkg::CTRL_SOFT_RESET_BIT];
      end else if (protected_hit && st_r.wp_on) begin
        st_nxt.wp_flag = 1'b1;
        st_nxt.wp_src = {{(mic_regs_pkg::WP_SRC_W - 12){1'b0}}, ofs};
      end else if (hit(ofs, mic_regs_pkg::OFS_MODE)) begin
        st_nxt.mode = (st_r.mode & ~mic_regs_pkg::WMASK_MODE) |
                      (pwdata_i & mic_regs_pkg::WMASK_MODE);
      end else if (hit(ofs, mic_regs_pkg::OFS_FILTER_A)) begin
        st_nxt.filt_a = pwdata_i & mic_regs_pkg::WMASK_FILTER_A;
      end else if (hit(ofs, mic_regs_pkg::OFS_FILTER_B)) begin
        st_nxt.filt_b = pwdata_i & mic_regs_pkg::WMASK_FILTER_B;
      end else if (hit(ofs, mic_regs_pkg::OFS_IRQ_ENABLE)) begin
        st_nxt.mask = st_r.mask | pick_sources(pwdata_i);
      end else if (hit(ofs, mic_regs_pkg::OFS_IRQ_DISABLE)) begin
        st_nxt.mask = st_r.mask & ~pick_sources(pwdata_i);
      end else if (hit(ofs, mic_regs_pkg::OFS_WP_MODE)) begin
        st_nxt.wp_on = pwdata_i[mic_regs_pkg::WP_ON_BIT];
      end
    end
    if (store) begin
      // 16-bit result unless 32-bit size is selected
      if (st_r.filt_a[mic_regs_pkg::FILTER_A_SIZE_BIT]) begin
        st_nxt.sample = sample_data_i;
      end else begin
        st_nxt.sample = {16'h0000, sample_data_i[mic_regs_pkg::SAMPLE_W-1:0]};
      end
      st_nxt.ready = 1'b1;
      st_nxt.dma_req = 1'b1;
    end
    if (overrun_evt) begin
      st_nxt.overrun = 1'b1;
    end
    status_nxt = {rx_full, rx_done, st_nxt.overrun, st_nxt.ready};
    st_nxt.irq = |(status_nxt & st_nxt.mask);
    // soft reset restores every reset value
    if (st_r.soft_reset_bit) begin
      st_nxt = RESET_STATE;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= RESET_STATE;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  mic_clock_divider #(
    .DIV_W(mic_regs_pkg::DIVIDER_W)
  ) u_divider (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .run_i(st_r.run),
    .clear_i(st_r.soft_reset_bit),
    .divider_i(st_r.mode[mic_regs_pkg::DIVIDER_LSB +: mic_regs_pkg::DIVIDER_W]),
    .mic_sample_clock_o(mic_sample_clock_o)
  );

  rx_buffer_status u_rx_status (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .clear_i(st_r.soft_reset_bit),
    .count_zero_i(dma_rx_counter_zero_i),
    .next_count_zero_i(dma_rx_next_counter_zero_i),
    .counter_write_i(dma_counter_write_i),
    .rx_count_done_flag_o(rx_done),
    .rx_buffers_full_flag_o(rx_full)
  );

  assign prdata_o = st_r.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign dma_data_o = st_r.sample[mic_regs_pkg::SAMPLE_W-1:0];
  assign dma_req_o = st_r.dma_req;
  assign conversion_run_o = st_r.run;
  assign soft_reset_o = st_r.soft_reset_bit;
  assign filter_config_a_o = st_r.filt_a;
  assign filter_config_b_o = st_r.filt_b;
  assign irq_o = st_r.irq;

endmodule

// >>> rtl/mic_clock_divider.sv
// Divider that makes the microphone sample clock from the core clock
`timescale 1ns/1ps
module mic_clock_divider #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // Control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [DIV_W-1:0] divider_i,
  // Clock out
  output logic mic_sample_clock_o
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic clk;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clear_i || !run_i) begin
      st_nxt = '0;
    end else if (st_r.cnt >= divider_i) begin
      st_nxt.cnt = '0;
      st_nxt.clk = ~st_r.clk;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign mic_sample_clock_o = st_r.clk;

endmodule

// >>> rtl/mic_regs_pkg.sv
// Register map, field layout and reset values of the microphone result block
package mic_regs_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_SAMPLE = 12'h014;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h018;
  localparam logic [11:0] OFS_IRQ_DISABLE = 12'h01C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h024;
  localparam logic [11:0] OFS_FILTER_A = 12'h058;
  localparam logic [11:0] OFS_FILTER_B = 12'h05C;
  localparam logic [11:0] OFS_WP_MODE = 12'h0E4;
  localparam logic [11:0] OFS_WP_STATUS = 12'h0E8;

  // Reset values
  localparam logic [31:0] RST_MODE = 32'h00F00000;
  localparam logic [31:0] RST_FILTER_A = 32'h00000000;
  localparam logic [31:0] RST_FILTER_B = 32'h00000001;

  // Writable bits
  localparam logic [31:0] WMASK_MODE = 32'h00007F00;
  localparam logic [31:0] WMASK_FILTER_A = 32'h0000FFFE;
  localparam logic [31:0] WMASK_FILTER_B = 32'hFFFF7FFF;

  // Field positions
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_RUN_BIT = 4;
  localparam int DIVIDER_LSB = 8;
  localparam int DIVIDER_W = 7;
  localparam int FILTER_A_SIZE_BIT = 3;
  localparam int IRQ_READY_BIT = 24;
  localparam int IRQ_OVERRUN_BIT = 25;
  localparam int IRQ_RX_DONE_BIT = 27;
  localparam int IRQ_RX_FULL_BIT = 28;
  localparam int QUEUED_LSB = 16;
  localparam int QUEUED_W = 8;
  localparam int WP_ON_BIT = 0;
  localparam int WP_FLAG_BIT = 0;
  localparam int WP_SRC_LSB = 8;
  localparam int WP_SRC_W = 16;
  localparam int SAMPLE_W = 16;

endpackage

// >>> rtl/rx_buffer_status.sv
// Receive-done and buffers-full flags driven by the DMA counters
`timescale 1ns/1ps
module rx_buffer_status (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic clear_i,
  // DMA counter state
  input wire logic count_zero_i,
  input wire logic next_count_zero_i,
  input wire logic counter_write_i,
  // Flags
  output logic rx_count_done_flag_o,
  output logic rx_buffers_full_flag_o
);

  typedef struct packed {
    logic done;
    logic full;
    logic zero_q;
    logic both_q;
  } rx_state_t;

  rx_state_t st_r;
  rx_state_t st_nxt;
  logic both_zero;

  assign both_zero = count_zero_i && next_count_zero_i;

  // set on reaching zero, cleared by counter write, set wins
  always_comb begin
    st_nxt = st_r;
    st_nxt.zero_q = count_zero_i;
    st_nxt.both_q = both_zero;
    if (counter_write_i) begin
      st_nxt.done = 1'b0;
      st_nxt.full = 1'b0;
    end
    if (count_zero_i && !st_r.zero_q) begin
      st_nxt.done = 1'b1;
    end
    if (both_zero && !st_r.both_q) begin
      st_nxt.full = 1'b1;
    end
    if (clear_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign rx_count_done_flag_o = st_r.done;
  assign rx_buffers_full_flag_o = st_r.full;

endmodule

// >>> verif/mic_bitstream_controller_bench.sv
// Self-checking bench for the microphone result block
`timescale 1ns/1ps
module mic_bitstream_controller_bench;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, sample_data_i, fa, fb, r;
  logic pready_o, pslverr_o, sample_valid_i, rz, nz, cw, dma_req_o, run, srst, mclk, irq_o;
  logic [7:0] qc;
  logic [15:0] dma_data_o;
  logic [11:0] ra [11] = '{12'h000, 12'h004, 12'h014, 12'h020, 12'h024, 12'h058, 12'h05C,
    12'h0E4, 12'h0E8, 12'h0F0, 12'h100};
  logic [31:0] rv [11] = '{32'h0, 32'h00F00000, 32'h0, 32'h0, 32'h003C0000, 32'h0, 32'h1,
    32'h0, 32'h0, 32'h0, 32'h0};
  int failures = 0;
  int n_checks = 0;
  int p;
  always #12.5 core_clk_i = ~core_clk_i;
  mic_bitstream_controller u_dut (.core_clk_i, .nrst_i, .clk_en_i(1'b1), .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sample_valid_i,
    .sample_data_i, .queued_sample_count_i(qc), .dma_rx_counter_zero_i(rz),
    .dma_rx_next_counter_zero_i(nz), .dma_counter_write_i(cw), .dma_req_o, .dma_data_o,
    .conversion_run_o(run), .soft_reset_o(srst), .mic_sample_clock_o(mclk),
    .filter_config_a_o(fa), .filter_config_b_o(fb), .irq_o);
  mic_sample_source u_src (.core_clk_i, .sample_valid_o(sample_valid_i),
    .sample_data_o(sample_data_i), .queued_o(qc), .rx_zero_o(rz), .next_zero_o(nz),
    .cnt_wr_o(cw));
  task automatic finish_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; read data lands in r
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), r, e);
  endtask
  // Cycles between two rising edges of the sample clock
  task automatic period(output int q);
    int n, r0;
    logic pv;
    r0 = -1;
    q = 0;
    pv = 1'b1;
    for (n = 0; n < 200 && q == 0; n++) begin
      @(posedge core_clk_i);
      if (mclk === 1'b1 && pv === 1'b0) begin
        if (r0 >= 0) q = n - r0;
        else r0 = n;
      end
      pv = mclk;
    end
  endtask
  initial begin
    repeat (5000) @(posedge core_clk_i);
    failures++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 11; i++) rdc(ra[i], rv[i]);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    chk("slverr", 32'(pslverr_o), 32'h0);
    rdc(12'h100, 32'h0);
    u_src.send(32'h00001234);
    @(negedge core_clk_i);
    chk("req", 32'(dma_req_o), 32'h0);
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h018, 32'h1B000000);
    rdc(12'h020, 32'h1B000000);
    apb(1'b1, 12'h01C, 32'h1A000000);
    rdc(12'h020, 32'h01000000);
    chk("run", 32'(run), 32'h1);
    u_src.send(32'hABCD5A5A);
    @(negedge core_clk_i);
    chk("req", 32'(dma_req_o), 32'h1);
    chk("dma", 32'(dma_data_o), 32'h5A5A);
    chk("irq", 32'(irq_o), 32'h1);
    u_src.send(32'h00001111);
    @(negedge core_clk_i);
    chk("req", 32'(dma_req_o), 32'h0);
    rdc(12'h024, 32'h033C0000);
    rdc(12'h024, 32'h013C0000);
    rdc(12'h014, 32'h00005A5A);
    rdc(12'h024, 32'h003C0000);
    apb(1'b1, 12'h018, 32'h18000000);
    @(negedge core_clk_i);
    chk("irq", 32'(irq_o), 32'h0);
    u_src.set_zero(1'b1, 1'b0);
    rdc(12'h024, 32'h083C0000);
    u_src.set_zero(1'b1, 1'b1);
    rdc(12'h024, 32'h183C0000);
    @(negedge core_clk_i);
    chk("irq", 32'(irq_o), 32'h1);
    u_src.reload();
    rdc(12'h024, 32'h003C0000);
    @(negedge core_clk_i);
    chk("irq", 32'(irq_o), 32'h0);
    apb(1'b1, 12'h004, 32'h00000300);
    rdc(12'h004, 32'h00F00300);
    period(p);
    chk("period", p, 32'h8);
    apb(1'b1, 12'h0E4, 32'h1);
    apb(1'b1, 12'h004, 32'h00000700);
    apb(1'b1, 12'h05C, 32'h0);
    rdc(12'h004, 32'h00F00300);
    chk("cfg_b", fb, 32'h1);
    rdc(12'h0E8, 32'h00005C01);
    rdc(12'h0E8, 32'h00005C00);
    apb(1'b1, 12'h0E4, 32'h0);
    apb(1'b1, 12'h058, 32'h0000FFFF);
    @(negedge core_clk_i);
    chk("cfg_a", fa, 32'h0000FFFE);
    apb(1'b1, 12'h000, 32'h1);
    @(negedge core_clk_i);
    chk("srst", 32'(srst), 32'h1);
    repeat (3) @(posedge core_clk_i);
    rdc(12'h004, 32'h00F00000);
    rdc(12'h000, 32'h0);
    rdc(12'h020, 32'h0);
    chk("run", 32'(run), 32'h0);
    finish_test();
  end
endmodule

// >>> verif/mic_bitstream_controller_checker.sv
// Assertions on the result block's ports
`timescale 1ns/1ps
module mic_bitstream_controller_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  // Samples and outputs
  input wire logic sample_valid_i,
  input wire logic [31:0] sample_data_i,
  input wire logic dma_req_o,
  input wire logic [mic_regs_pkg::SAMPLE_W-1:0] dma_data_o,
  input wire logic conversion_run_o,
  input wire logic soft_reset_o,
  input wire logic mic_sample_clock_o,
  input wire logic [31:0] filter_config_a_o,
  input wire logic [31:0] filter_config_b_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic ctrl_wr;
  logic setup_rd;
  assign ctrl_wr = psel_i && penable_i && pwrite_i && clk_en_i && paddr_i == '0;
  assign setup_rd = psel_i && !penable_i && !pwrite_i && clk_en_i;
  a_req_has_cause:
    assert property (dma_req_o |-> $past(sample_valid_i && conversion_run_o))
    else $error("dma request without a stored sample");
  a_req_data_match:
    assert property (dma_req_o |-> dma_data_o == $past(sample_data_i[15:0]))
    else $error("dma data is not the latest sample");
  a_data_holds:
    assert property ($changed(dma_data_o) |-> dma_req_o || $past(soft_reset_o))
    else $error("stored sample changed without a new result");
  a_soft_reset_go:
    assert property (ctrl_wr && pwdata_i[0] |-> ##[1:2] soft_reset_o)
    else $error("soft reset not started");
  a_reset_clears:
    assert property (soft_reset_o |=> !conversion_run_o && !dma_req_o && !irq_o
      && filter_config_a_o == 32'h0 && filter_config_b_o == 32'h1)
    else $error("soft reset left state behind");
  a_run_follows:
    assert property (ctrl_wr && !pwdata_i[0] |-> ##2 conversion_run_o == $past(pwdata_i[4], 2))
    else $error("run bit does not follow control write");
  a_reserved_zero:
    assert property (setup_rd && paddr_i == 12'h0F0 |=> prdata_o == 32'h0)
    else $error("reserved offset read not zero");
  a_ctrl_reads_zero:
    assert property (setup_rd && paddr_i == '0 |=> !prdata_o[0])
    else $error("soft reset bit read as one");
  a_stop_clock_low:
    assert property (!conversion_run_o [*4] |-> !mic_sample_clock_o)
    else $error("sample clock runs while stopped");
  c_sample_stored: cover property (dma_req_o);
  c_soft_reset: cover property (soft_reset_o);
  c_irq_raised: cover property ($rose(irq_o));
endmodule
bind mic_bitstream_controller mic_bitstream_controller_checker #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i, .nrst_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .sample_valid_i, .sample_data_i, .dma_req_o, .dma_data_o, .conversion_run_o,
  .soft_reset_o, .mic_sample_clock_o, .filter_config_a_o, .filter_config_b_o, .irq_o);

// >>> verif/mic_sample_source.sv
// Model of the filter chain and DMA counters feeding the result block
`timescale 1ns/1ps
module mic_sample_source (
  // Clock
  input wire logic core_clk_i,
  // Filtered samples
  output logic sample_valid_o,
  output logic [31:0] sample_data_o,
  output logic [7:0] queued_o,
  // DMA counter state
  output logic rx_zero_o,
  output logic next_zero_o,
  output logic cnt_wr_o
);
  initial begin
    sample_valid_o = 1'b0;
    sample_data_o = 32'h0;
    queued_o = 8'h3C;
    rx_zero_o = 1'b0;
    next_zero_o = 1'b0;
    cnt_wr_o = 1'b0;
  end
  // One result per call; data is not held after the strobe
  task automatic send(input logic [31:0] d);
    @(posedge core_clk_i);
    sample_valid_o <= 1'b1;
    sample_data_o <= d;
    @(posedge core_clk_i);
    sample_valid_o <= 1'b0;
    sample_data_o <= ~d;
  endtask
  // Counters reach zero
  task automatic set_zero(input logic cur, input logic nxt);
    @(posedge core_clk_i);
    rx_zero_o <= cur;
    next_zero_o <= nxt;
  endtask
  // Counter reload: both counters non-zero again
  task automatic reload();
    @(posedge core_clk_i);
    cnt_wr_o <= 1'b1;
    rx_zero_o <= 1'b0;
    next_zero_o <= 1'b0;
    @(posedge core_clk_i);
    cnt_wr_o <= 1'b0;
  endtask
endmodule
